/* include/esq_cfg.svh */
// constants for the energy store sequencer: offsets, timings, limits, codes
`ifndef ESQ_CFG_SVH
`define ESQ_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets on the apb port
// ----------------------------------------------------------------------
`define ESQ_CTRL_OFS      12'h000
`define ESQ_STAT_OFS      12'h004
`define ESQ_LEVEL_OFS     12'h008
`define ESQ_ADDR_W        12

// ctrl fields
`define ESQ_CTRL_CLR_BIT  0
`define ESQ_CTRL_DIS_BIT  1
`define ESQ_CTRL_RST      2'h0

// ----------------------------------------------------------------------
// timing, in milliseconds as quoted, and the clock rate
// ----------------------------------------------------------------------
`define ESQ_CLK_KHZ       40000
`define ESQ_CHG_MS        5000
`define ESQ_DIS_MS        20000
`define ESQ_RDY_MS        10000

// ----------------------------------------------------------------------
// mains current limits in arms, one per switch code
// ----------------------------------------------------------------------
`define ESQ_LIM_W         8
`define ESQ_LIM_0000      8'h2a
`define ESQ_LIM_TABLE {8'hb0, 8'ha1, 8'h8f, 8'h80, 8'h71, 8'h63, 8'h58, \
   8'h52, 8'h49, 8'h42, 8'h39, 8'h36, 8'h32, 8'h2d, 8'h2a, `ESQ_LIM_0000}

// ----------------------------------------------------------------------
// alarm codes raised by the sequencer itself
// ----------------------------------------------------------------------
`define ESQ_ALM_NONE      4'h0
`define ESQ_ALM_CHARGE    4'he
`define ESQ_ALM_DISCHG    4'hf

`endif

/* include/esq_pkg.sv */
// types shared by the energy store sequencer
package esq_pkg;

   // sequencer states
   typedef enum logic [2:0] {
      ESQ_IDLE,
      ESQ_CHARGE,
      ESQ_READY,
      ESQ_DISCHARGE,
      ESQ_ALARM
   } esq_state_e;

   // word received from the supply over the module link
   typedef struct packed {
      logic valid;          // one-cycle strobe, fields below are new
      logic estop_n;        // low means emergency stop
      logic supply_ready_n; // low means supply ready
      logic estop_at_supply;// stop came in at the supply input
   } esq_link_s;

   // alarm report from the power stage monitors
   typedef struct packed {
      logic       valid;    // one-cycle strobe
      logic       serious;  // serious class, both status bits low
      logic [3:0] kind;     // alarm kind code
   } esq_alarm_s;

endpackage : esq_pkg

/* verilog/esq_sequencer.sv */
// energy store sequencer: charge, ready, discharge, assist and alarm logic
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "esq_cfg.svh"

module esq_sequencer #(
   parameter int DEMAND_W = `ESQ_LIM_W,
   parameter int CHG_CYC  = `ESQ_CHG_MS * `ESQ_CLK_KHZ,
   parameter int DIS_CYC  = `ESQ_DIS_MS * `ESQ_CLK_KHZ,
   parameter int RDY_CYC  = `ESQ_RDY_MS * `ESQ_CLK_KHZ
) (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   // module link from the supply
   input  wire esq_pkg::esq_link_s    link_in,
   // configuration switch and power stage sense
   input  wire logic [3:0]            level_sw,
   input  wire logic [DEMAND_W-1:0]   demand_current,
   input  wire esq_pkg::esq_alarm_s   alarm_in,
   input  wire logic                  discharge_fault,
   // controller discrete inputs
   input  wire logic                  discharge_inhibit,
   input  wire logic                  supply_inhibit,
   // controller discrete outputs
   output logic                       assist_ready,
   output logic                       status_bit_lo,
   output logic                       status_bit_hi,
   output logic [3:0]                 alarm_kind_code,
   // power stage drives
   output logic                       assist_on,
   output logic                       amp_path_on,
   output logic                       discharge_on,
   output logic                       discharge_amp_on
);

   // -------------------------------------------------------------------
   // parameter checks
   // -------------------------------------------------------------------
   initial begin
      if (DEMAND_W < `ESQ_LIM_W || CHG_CYC < 1 || DIS_CYC < 1 ||
          RDY_CYC < 1) begin
         $error("esq_sequencer: unsupported parameter values");
      end
   end

   localparam logic [`ESQ_LIM_W*16-1:0] LIM_TAB = `ESQ_LIM_TABLE;

   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   esq_pkg::esq_state_e state_reg;   // sequencer state
   logic [31:0]  tmr_reg;            // charge / discharge timer
   logic [31:0]  win_reg;            // ready window after release
   logic         estop_reg;          // emergency stop active
   logic         sup_ready_reg;      // supply reports ready
   logic         at_supply_reg;      // stop entered at supply input
   logic         alm_act_reg;        // alarm latched
   logic         alm_ser_reg;        // latched alarm is serious
   logic [3:0]   alm_kind_reg;       // latched alarm kind
   logic [3:0]   level_reg;          // sampled switch code
   logic [`ESQ_LIM_W-1:0] limit_reg; // selected mains limit
   logic         assist_dis_reg;     // software assist disable
   logic         clr_req;            // software alarm clear, this cycle
   logic         wr_en;              // apb write takes effect
   logic         win_alarm;          // ready window overrun
   logic         dis_alarm;          // discharge circuit failure
   logic         new_alarm;          // any alarm event this cycle
   logic [3:0]   new_kind;           // its kind
   logic         new_serious;        // its class
   logic         discharging;        // discharge current allowed
   logic         sel_ctrl;
   logic         sel_stat;
   logic         sel_level;

   // -------------------------------------------------------------------
   // apb slave: one wait-free access phase, registered answer
   // -------------------------------------------------------------------
   assign sel_ctrl  = paddr[`ESQ_ADDR_W-1:0] == `ESQ_CTRL_OFS;
   assign sel_stat  = paddr[`ESQ_ADDR_W-1:0] == `ESQ_STAT_OFS;
   assign sel_level = paddr[`ESQ_ADDR_W-1:0] == `ESQ_LEVEL_OFS;
   assign wr_en     = psel && penable && pready && pwrite;
   assign clr_req   = wr_en && sel_ctrl && pwdata[`ESQ_CTRL_CLR_BIT];

   // pready rises in the access phase right after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable &&
                    !(sel_ctrl || sel_stat || sel_level);
         if (psel && !penable && !pwrite) begin
            // read data is captured at setup so it comes from a flop
            if (sel_ctrl) begin
               prdata <= {30'h0, assist_dis_reg, 1'b0};
            end else if (sel_stat) begin
               prdata <= {17'h0, alm_kind_reg, alm_ser_reg, alm_act_reg,
                          at_supply_reg, sup_ready_reg, estop_reg,
                          state_reg, assist_ready, status_bit_hi,
                          status_bit_lo};
            end else if (sel_level) begin
               prdata <= {20'h0, level_reg, limit_reg};
            end else begin
               prdata <= 32'h0;   // unmapped reads as zero
            end
         end
      end
   end

   // software assist disable; clear bit is a pulse, not stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         assist_dis_reg <= 1'(`ESQ_CTRL_RST >> `ESQ_CTRL_DIS_BIT);
      end else if (wr_en && sel_ctrl) begin
         assist_dis_reg <= pwdata[`ESQ_CTRL_DIS_BIT];
      end
   end

   // -------------------------------------------------------------------
   // link state, polarities decoded here
   // -------------------------------------------------------------------
   // starts in stop with supply not ready until the first link word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         estop_reg     <= 1'b1;
         sup_ready_reg <= 1'b0;
         at_supply_reg <= 1'b0;
      end else if (link_in.valid) begin
         estop_reg     <= !link_in.estop_n;
         sup_ready_reg <= !link_in.supply_ready_n;
         at_supply_reg <= !link_in.estop_n && link_in.estop_at_supply;
      end
   end

   // -------------------------------------------------------------------
   // level switch: off reads one, switch 1 is bit 0
   // -------------------------------------------------------------------
   // the switch is a static strap, so sampling every cycle is enough
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= 4'h0;
         limit_reg <= `ESQ_LIM_0000;
      end else begin
         level_reg <= level_sw;
         limit_reg <= LIM_TAB[level_sw*`ESQ_LIM_W +: `ESQ_LIM_W];
      end
   end

   // -------------------------------------------------------------------
   // alarm events and latch
   // -------------------------------------------------------------------
   assign win_alarm = win_reg >= 32'(RDY_CYC - 1);
   assign dis_alarm = discharge_fault && state_reg == esq_pkg::ESQ_DISCHARGE;

   always_comb begin
      new_alarm   = alarm_in.valid || win_alarm || dis_alarm;
      new_serious = 1'b0;
      new_kind    = `ESQ_ALM_NONE;
      if (alarm_in.valid) begin
         new_kind    = alarm_in.kind;
         new_serious = alarm_in.serious;
      end else if (dis_alarm) begin
         new_kind    = `ESQ_ALM_DISCHG;
         new_serious = 1'b1;
      end else if (win_alarm) begin
         new_kind    = `ESQ_ALM_CHARGE;
      end
   end

   // a new alarm in the clearing cycle wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alm_act_reg  <= 1'b0;
         alm_ser_reg  <= 1'b0;
         alm_kind_reg <= `ESQ_ALM_NONE;
      end else if (new_alarm) begin
         alm_act_reg  <= 1'b1;
         alm_ser_reg  <= alm_ser_reg || new_serious;
         alm_kind_reg <= new_kind;
      end else if (clr_req) begin
         alm_act_reg  <= 1'b0;
         alm_ser_reg  <= 1'b0;
         alm_kind_reg <= `ESQ_ALM_NONE;
      end
   end

   // -------------------------------------------------------------------
   // ready window: runs from stop release until ready or alarm
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_reg <= 32'h0;
      end else if (estop_reg || alm_act_reg || win_alarm ||
                   state_reg == esq_pkg::ESQ_READY) begin
         win_reg <= 32'h0;
      end else begin
         win_reg <= win_reg + 32'h1;
      end
   end

   // -------------------------------------------------------------------
   // sequencer state machine
   // -------------------------------------------------------------------
   // discharge goes through the resistor unless inhibited; a stop
   // taken at the supply input overrides the inhibit, and a failed
   // discharge circuit never discharges
   assign discharging = state_reg == esq_pkg::ESQ_DISCHARGE &&
                        !discharge_fault &&
                        (!discharge_inhibit || at_supply_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= esq_pkg::ESQ_IDLE;
         tmr_reg   <= 32'h0;
      end else if (new_alarm) begin
         state_reg <= esq_pkg::ESQ_ALARM;
         tmr_reg   <= 32'h0;
      end else begin
         unique case (state_reg)
            esq_pkg::ESQ_IDLE: begin
               tmr_reg <= 32'h0;
               if (!estop_reg && sup_ready_reg) begin
                  state_reg <= esq_pkg::ESQ_CHARGE;
               end
            end
            esq_pkg::ESQ_CHARGE: begin
               if (estop_reg) begin
                  state_reg <= esq_pkg::ESQ_DISCHARGE;
                  tmr_reg   <= 32'h0;
               end else if (!sup_ready_reg) begin
                  state_reg <= esq_pkg::ESQ_IDLE;
               end else if (tmr_reg >= 32'(CHG_CYC - 1)) begin
                  state_reg <= esq_pkg::ESQ_READY;
                  tmr_reg   <= 32'h0;
               end else begin
                  tmr_reg <= tmr_reg + 32'h1;
               end
            end
            esq_pkg::ESQ_READY: begin
               if (estop_reg) begin
                  state_reg <= esq_pkg::ESQ_DISCHARGE;
               end else if (!sup_ready_reg) begin
                  state_reg <= esq_pkg::ESQ_IDLE;
               end
            end
            esq_pkg::ESQ_DISCHARGE: begin
               // release mid-discharge recharges the held energy
               if (!estop_reg) begin
                  state_reg <= esq_pkg::ESQ_IDLE;
                  tmr_reg   <= 32'h0;
               end else if (tmr_reg >= 32'(DIS_CYC - 1)) begin
                  state_reg <= esq_pkg::ESQ_IDLE;
                  tmr_reg   <= 32'h0;
               end else if (discharging) begin
                  tmr_reg <= tmr_reg + 32'h1;
               end
            end
            esq_pkg::ESQ_ALARM: begin
               if (!alm_act_reg) begin
                  state_reg <= esq_pkg::ESQ_IDLE;
               end
            end
            default: begin
               state_reg <= esq_pkg::ESQ_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // controller outputs, all registered
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         assist_ready    <= 1'b0;
         status_bit_lo   <= 1'b1;
         status_bit_hi   <= 1'b1;
         alarm_kind_code <= `ESQ_ALM_NONE;
      end else begin
         assist_ready    <= state_reg == esq_pkg::ESQ_READY &&
                            !new_alarm;
         status_bit_lo   <= !(alm_act_reg || new_alarm);
         status_bit_hi   <= !(alm_ser_reg ||
                              (new_alarm && new_serious));
         alarm_kind_code <= new_alarm ? new_kind : alm_kind_reg;
      end
   end

   // -------------------------------------------------------------------
   // power stage drives
   // -------------------------------------------------------------------
   // the amplifier path is cut in every state but ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         assist_on        <= 1'b0;
         amp_path_on      <= 1'b0;
         discharge_on     <= 1'b0;
         discharge_amp_on <= 1'b0;
      end else begin
         amp_path_on      <= state_reg == esq_pkg::ESQ_READY &&
                             !new_alarm && !estop_reg;
         assist_on        <= state_reg == esq_pkg::ESQ_READY &&
                             !new_alarm && !estop_reg &&
                             !supply_inhibit &&
                             !assist_dis_reg &&
                             demand_current > DEMAND_W'(limit_reg);
         discharge_on     <= discharging && !new_alarm;
         discharge_amp_on <= discharging && !new_alarm &&
                             at_supply_reg;
      end
   end

endmodule : esq_sequencer

/* verification/esq_seq_properties.sv */
// concurrent checks on the energy store sequencer ports
`timescale 1ns/100ps
`include "esq_cfg.svh"

module esq_seq_checker #(
   parameter int DEMAND_W = 8
) (
   // clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // link, switch and sense inputs
   input wire esq_pkg::esq_link_s  link_in,
   input wire logic [3:0]          level_sw,
   input wire logic [DEMAND_W-1:0] demand_current,
   input wire esq_pkg::esq_alarm_s alarm_in,
   input wire logic                discharge_fault,
   // controller inputs
   input wire logic                discharge_inhibit,
   input wire logic                supply_inhibit,
   // controller and power stage outputs
   input wire logic                assist_ready,
   input wire logic                status_bit_lo,
   input wire logic                status_bit_hi,
   input wire logic [3:0]          alarm_kind_code,
   input wire logic                assist_on,
   input wire logic                amp_path_on,
   input wire logic                discharge_on,
   input wire logic                discharge_amp_on
);
   // ---------------------------------------------------------------
   // helper state and properties
   // ---------------------------------------------------------------
   localparam logic [127:0] LIM = `ESQ_LIM_TABLE; // code 0 in low byte
   logic                    at_sup_q;             // stop came at supply

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // where the last stop entered; only the strobe makes it count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         at_sup_q <= 1'b0;
      else if (link_in.valid)
         at_sup_q <= link_in.estop_at_supply;
   end

   a_assist_above_lim: assert property (
      assist_on |-> $past(demand_current) > LIM[$past(level_sw, 2)*8 +: 8])
      else $error("assist on at or below the limit");
   a_assist_inhibit: assert property (
      assist_on |-> !$past(supply_inhibit))
      else $error("assist on while withheld");
   a_alarm_stops_all: assert property (
      alarm_in.valid |=> !status_bit_lo && !assist_on && !amp_path_on)
      else $error("alarm left functions running");
   a_serious_both_low: assert property (
      alarm_in.valid && alarm_in.serious |=> !status_bit_hi)
      else $error("serious alarm kept upper status bit");
   a_alarm_kind_shown: assert property (
      alarm_in.valid |=> alarm_kind_code == $past(alarm_in.kind))
      else $error("alarm code differs from kind");
   a_status_legal: assert property (status_bit_hi || !status_bit_lo)
      else $error("status pair has an unused encoding");
   a_stop_drops_ready: assert property (
      link_in.valid && !link_in.estop_n |-> ##[1:5]
      (!assist_ready && !amp_path_on))
      else $error("stop did not drop ready and path");
   a_inhibit_holds: assert property (
      discharge_on |-> !$past(discharge_inhibit) || $past(at_sup_q))
      else $error("discharge while inhibited");
   a_amp_dis_supply: assert property (
      discharge_amp_on |-> $past(at_sup_q))
      else $error("amplifier discharge without supply stop");
   a_fault_no_dis: assert property (
      discharge_on && discharge_fault |=>
      !discharge_on && alarm_kind_code == 4'hf)
      else $error("broken discharge kept running");
endmodule : esq_seq_checker

bind esq_sequencer esq_seq_checker #(.DEMAND_W(DEMAND_W)) esq_seq_chk (
   .pclk, .presetn, .link_in, .level_sw, .demand_current, .alarm_in,
   .discharge_fault, .discharge_inhibit, .supply_inhibit, .assist_ready,
   .status_bit_lo, .status_bit_hi, .alarm_kind_code, .assist_on,
   .amp_path_on, .discharge_on, .discharge_amp_on);

/* verification/esq_supply_model.sv */
// supply link sender and controller input view, behavioural
`timescale 1ns/100ps

module esq_supply_model (
   // clock
   input  wire logic          pclk,
   // device outputs arriving at the controller inputs
   input  wire logic          assist_ready,
   input  wire logic          status_bit_lo,
   input  wire logic          status_bit_hi,
   // link word toward the device, controller side results
   output esq_pkg::esq_link_s link_in,
   output logic               main_contactor,
   output logic [2:0]         seen
);
   // ---------------------------------------------------------------
   // link words and controller view
   // ---------------------------------------------------------------
   // inputs have pull-downs: anything not sourced high reads low
   assign seen = {assist_ready === 1'b1, status_bit_hi === 1'b1,
                  status_bit_lo === 1'b1};

   initial begin
      link_in        = '0;
      main_contactor = 1'b0;
   end

   // one word a call; fields scrambled once the strobe drops so a
   // device that reads them without the strobe shows it
   task send(input logic e_n, input logic r_n, input logic at_sup);
      @(posedge pclk);
      link_in        <= {1'b1, e_n, r_n, at_sup};
      main_contactor <= e_n;
      @(posedge pclk);
      link_in        <= {1'b0, ~e_n, ~r_n, ~at_sup};
   endtask : send
endmodule : esq_supply_model

/* verification/testbench.sv */
// self-checking bench for the energy store sequencer
`timescale 1ns/100ps

module testbench;
   // ---------------------------------------------------------------
   // signals, design and far side
   // ---------------------------------------------------------------
   localparam int CHG = 20;                 // short charge count
   localparam int DIS = 40;                 // short discharge count
   localparam int RDY = 60;                 // short ready window
   logic                pclk, presetn, psel, penable, pwrite;
   logic                pready, pslverr, err, dis_fault, dis_inh;
   logic                sup_inh, assist_ready, st_lo, st_hi, mc;
   logic                assist_on, amp_on, dis_on, dis_amp_on;
   logic [31:0]         paddr, pwdata, prdata, rd;
   logic [3:0]          level_sw, alarm_kind_code;
   logic [7:0]          demand;             // motor demand, arms
   logic [2:0]          seen;               // {ready, hi, lo} as read
   esq_pkg::esq_link_s  link;
   esq_pkg::esq_alarm_s alarm;
   int                  num_errors = 0, n_compared = 0, cyc = 0;
   int                  n, k, seed;
   // mains limit per switch code; code 0 reads as the lowest
   int lim[16] = '{42,42,45,50,54,57,66,73,82,88,99,113,128,143,161,176};

   esq_sequencer #(.CHG_CYC(CHG), .DIS_CYC(DIS), .RDY_CYC(RDY))
      esq_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .link_in(link),
      .level_sw(level_sw), .demand_current(demand), .alarm_in(alarm),
      .discharge_fault(dis_fault), .discharge_inhibit(dis_inh),
      .supply_inhibit(sup_inh), .assist_ready(assist_ready),
      .status_bit_lo(st_lo), .status_bit_hi(st_hi),
      .alarm_kind_code(alarm_kind_code), .assist_on(assist_on),
      .amp_path_on(amp_on), .discharge_on(dis_on),
      .discharge_amp_on(dis_amp_on));
   esq_supply_model esq_supply_model_inst (.pclk(pclk),
      .assist_ready(assist_ready), .status_bit_lo(st_lo),
      .status_bit_hi(st_hi), .link_in(link), .main_contactor(mc),
      .seen(seen));

   initial pclk = 1'b0;
   always #12.5 pclk = ~pclk;

   // hang guard: the whole run needs well under two thousand cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         conclude;
      end
   end

   task conclude;
      if (num_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task tick(input int c);
      repeat (c) @(posedge pclk);
   endtask : tick

   // one apb transfer; read data and error are taken with pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {20'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no limit of its own: the hang guard ends a wait that never ends
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wait_rdy;
      n = 0;
      while (seen[2] !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_rdy

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {dis_fault, dis_inh, sup_inh, demand, alarm} = '0;
      level_sw = 4'h1;
      seed = 32'h149d;
      presetn = 1'b0;
      tick(20);
      presetn <= 1'b1;
      tick(1);
      chk({seen, alarm_kind_code}, {3'b011, 4'h0});
      // every switch code reads back its limit
      for (k = 0; k < 16; k++) begin
         level_sw <= k[3:0];
         tick(2);
         apb(1'b0, 12'h008, 32'h0);
         chk(rd[11:0], {k[3:0], lim[k][7:0]});
      end
      // unmapped place: refused, write lost, reads zero
      apb(1'b1, 12'h00c, 32'hffff_ffff);
      apb(1'b0, 12'h00c, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      // every alarm kind, odd kinds serious; software clears each
      for (k = 1; k < 16; k++) begin
         @(posedge pclk);
         alarm <= {1'b1, k[0], k[3:0]};
         @(posedge pclk);
         alarm <= '0;
         tick(1);
         chk({seen, alarm_kind_code}, {1'b0, ~k[0], 1'b0, k[3:0]});
         apb(1'b1, 12'h000, 32'h1);
         tick(2);
         chk({seen, alarm_kind_code}, {3'b011, 4'h0});
      end
      // released, supply not ready: no charge may start
      esq_supply_model_inst.send(1'b1, 1'b1, 1'b0);
      tick(CHG + 5);
      chk(seen[2], 1'b0);
      esq_supply_model_inst.send(1'b1, 1'b0, 1'b0);
      wait_rdy;
      chk(n >= CHG, 1'b1);
      chk(n + CHG + 9 <= RDY, 1'b1);
      // random demand and switch against the threshold
      for (k = 0; k < 24; k++) begin
         demand <= 8'($random(seed));
         level_sw <= 4'($random(seed));
         sup_inh <= (k % 4 == 3);
         tick(3);
         chk(assist_on, (demand > lim[level_sw]) && !sup_inh);
      end
      sup_inh <= 1'b0;
      // software disable holds assist off, reads back, then lets go
      demand <= 8'hff;
      apb(1'b1, 12'h000, 32'h2);
      apb(1'b0, 12'h000, 32'h0);
      chk({rd[1:0], assist_on}, 3'b100);
      // ready state: both status bits, ready, supply ready
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0000_0097);
      apb(1'b1, 12'h000, 32'h0);
      tick(2);
      chk(assist_on, 1'b1);
      // controller stop with discharge held off, then let go
      dis_inh <= 1'b1;
      esq_supply_model_inst.send(1'b0, 1'b0, 1'b0);
      tick(6);
      chk({seen[2], amp_on, dis_on, mc}, 4'b0000);
      dis_inh <= 1'b0;
      tick(3);
      chk({dis_on, dis_amp_on}, 2'b10);
      esq_supply_model_inst.send(1'b1, 1'b0, 1'b0);
      wait_rdy;
      chk(n + 2 <= RDY, 1'b1);
      // stop at the supply overrides the inhibit
      dis_inh <= 1'b1;
      esq_supply_model_inst.send(1'b0, 1'b0, 1'b1);
      tick(6);
      chk({seen[2], amp_on, dis_on, dis_amp_on}, 4'b0011);
      // broken discharge circuit mid-discharge
      dis_fault <= 1'b1;
      tick(3);
      chk({seen, dis_on, alarm_kind_code}, 8'h0f);
      dis_fault <= 1'b0;
      dis_inh <= 1'b0;
      apb(1'b1, 12'h000, 32'h1);
      tick(2);
      chk({seen, alarm_kind_code}, {3'b011, 4'h0});
      // released but supply never ready: charge alarm after window
      esq_supply_model_inst.send(1'b1, 1'b1, 1'b0);
      tick(RDY + 8);
      chk({seen[0], alarm_kind_code}, {1'b0, 4'he});
      conclude;
   end
endmodule : testbench
